// ### rtl/mis_monitor_irq.sv
/*
 Interrupt status, mask, intrusion-clear pulse and PROCESSOR_VOLTAGE_ID / tach prescale registers.
 Assumes register accesses arrive as one-cycle strobes on the core clock, and that
 limit-check events arrive as levels on the core clock. Pins are synchronised here.
*/
// Notes on behaviour
// R01: Voltage, fan channel violations set status A
// R02: Temperature channels set status A bits 4,5
// R03: 12V, core two set status B; 2,3 reserved
// R04: Intrusion input rising edge sets status B bit 4, except during own clear pulse
// R05: External low overtemp line sets bit 5
// R06: Diode faults set status B bits 6,7
// R07: Reading status clears it; reset zero
// R08: Unhandled remaining violations raise interrupt again
// R09: Mask bit blocks matching status bit
// R10: Masks read/write, reset to zero
// R11: Mask B reserved bits writable, reset low
// R12: Software masks persistent faults until fixed
// R13: Writing bit 7 drives 20 ms low pulse
// R14: Request bit self-clears after pulse ends
// R15: Intrusion-clear bits 0..6 read zero
// R16: PROCESSOR_VOLTAGE_ID bits reflect voltage ID pins
// R17: Bits 5:4 select tach one prescale
// R18: Bits 7:6 select tach two prescale
// R19: Interrupt driven only when enable bit set
// R20: Interrupt-clear bit hides irq, pauses monitoring
// R21: Interrupt while any unmasked status bit set
`timescale 1ns/100ps

module mis_monitor_irq (
	input  wire logic                 core_clk_i,
	input  wire logic                 rst_n_i,
	input  wire mis_pkg::mis_reg_req_s reg_req_i,
	output logic [7:0]                reg_rdata_o,
	input  wire mis_pkg::mis_events_s limit_events_i,
	input  wire logic                 irq_enable_i,
	input  wire logic                 irq_clear_i,
	output logic                      monitor_pause_o,
	output logic                      irq_o,
	input  wire logic                 intrusion_in_i,
	output logic                      intrusion_out_o,
	output logic                      intrusion_oe_n_o,
	input  wire logic                 overtemp_line_in_i,
	input  wire logic                 overtemp_drive_i,
	input  wire logic [3:0]           processor_voltage_id_i,
	output logic [1:0]                tach1_prescale_o,
	output logic [1:0]                tach2_prescale_o
);
	import mis_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [5:0] sync_a;
	logic [5:0] sync_b;
	logic       intrusion_prev;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			// Overtemp line idles high, so its stages reset high to avoid a false event
			sync_a <= MIS_RST_SYNC;
			sync_b <= MIS_RST_SYNC;
		end else begin
			sync_a <= {processor_voltage_id_i, overtemp_line_in_i, intrusion_in_i};
			sync_b <= sync_a;
		end
	end

	wire logic       intrusion_s = sync_b[0];
	wire logic       overtemp_s  = sync_b[1];
	wire logic [3:0] vid_s       = sync_b[5:2];

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			intrusion_prev <= 1'b0;
		else
			intrusion_prev <= intrusion_s;
	end

	// ----------------------------------------------------------------
	// Own overtemp drive, held over the synchroniser delay
	// ----------------------------------------------------------------
	logic [1:0] drive_d;
	wire logic  own_drive = overtemp_drive_i | drive_d[0] | drive_d[1];

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			drive_d <= 2'h0;
		else
			drive_d <= {drive_d[0], overtemp_drive_i};
	end

	// ----------------------------------------------------------------
	// Event collection
	// ----------------------------------------------------------------
	logic [7:0] status_a;
	logic [7:0] status_b;
	logic [7:0] mask_a;
	logic [7:0] mask_b;
	logic [7:0] set_a;
	logic [7:0] set_b;
	logic       pulse_active;

	assign monitor_pause_o = irq_clear_i; // see R20

	always_comb begin
		set_a = limit_events_i.events_a; // see R01 see R02
		set_b = limit_events_i.events_b & 8'hC3; // see R03 see R06
		// Rising intrusion edge, ignored while our own pulse holds the pin low
		set_b[MIS_BIT_INTRUSION] = intrusion_s & ~intrusion_prev & ~pulse_active; // see R04
		// Low line with no drive from the block means an external source
		set_b[MIS_BIT_OVERTEMP] = ~overtemp_s & ~own_drive; // see R05
		if (irq_clear_i) begin
			set_a = 8'h00;
			set_b = 8'h00;
		end
	end

	// ----------------------------------------------------------------
	// Status registers, read to clear, set wins
	// ----------------------------------------------------------------
	wire logic rd_a = reg_req_i.rd && reg_req_i.addr == MIS_OFS_STATUS_A;
	wire logic rd_b = reg_req_i.rd && reg_req_i.addr == MIS_OFS_STATUS_B;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			status_a <= MIS_RST_STATUS; // see R07
			status_b <= MIS_RST_STATUS;
		end else begin
			status_a <= (rd_a ? 8'h00 : status_a) | set_a; // see R07 see R08
			status_b <= (rd_b ? 8'h00 : status_b) | set_b;
		end
	end

	// ----------------------------------------------------------------
	// Mask registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mask_a <= MIS_RST_MASK; // see R10
			mask_b <= MIS_RST_MASK; // see R11
		end else if (reg_req_i.wr) begin
			if (reg_req_i.addr == MIS_OFS_MASK_A)
				mask_a <= reg_req_i.wdata; // see R10
			if (reg_req_i.addr == MIS_OFS_MASK_B)
				mask_b <= reg_req_i.wdata; // see R11
		end
	end

	// ----------------------------------------------------------------
	// Interrupt output
	// ----------------------------------------------------------------
	wire logic pending = |(status_a & ~mask_a) | |(status_b & ~mask_b); // see R09 see R21

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			irq_o <= 1'b0;
		else
			irq_o <= pending & irq_enable_i & ~irq_clear_i; // see R19 see R20
	end

	// ----------------------------------------------------------------
	// Intrusion clear pulse
	// ----------------------------------------------------------------
	mis_pulse_e pulse_state;
	logic [31:0] pulse_cnt;

	wire logic intr_req = reg_req_i.wr && reg_req_i.addr == MIS_OFS_INTR_CLR
		&& reg_req_i.wdata[MIS_BIT_INTR_REQ];

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pulse_state <= MIS_PULSE_IDLE;
			pulse_cnt   <= 32'h0;
		end else begin
			unique case (pulse_state)
				MIS_PULSE_IDLE: begin
					if (intr_req) begin
						pulse_state <= MIS_PULSE_LOW; // see R13
						pulse_cnt   <= 32'(MIS_PULSE_CYC - 1);
					end
				end
				MIS_PULSE_LOW: begin
					if (pulse_cnt == 32'h0)
						pulse_state <= MIS_PULSE_IDLE; // see R14
					else
						pulse_cnt <= pulse_cnt - 32'h1;
				end
				default: pulse_state <= MIS_PULSE_IDLE;
			endcase
		end
	end

	assign pulse_active     = pulse_state == MIS_PULSE_LOW;
	assign intrusion_out_o  = 1'b0;
	assign intrusion_oe_n_o = ~pulse_active; // see R13

	// Cycles spent driving the pin, watched by the length checks
	logic [31:0] low_cycles;

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			low_cycles <= 32'h0;
		else if (pulse_active)
			low_cycles <= low_cycles + 32'h1;
		else
			low_cycles <= 32'h0;
	end

	// ----------------------------------------------------------------
	// Prescale fields
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tach1_prescale_o <= MIS_RST_PRESCALE;
			tach2_prescale_o <= MIS_RST_PRESCALE;
		end else if (reg_req_i.wr && reg_req_i.addr == MIS_OFS_VID_TACH) begin
			tach1_prescale_o <= reg_req_i.wdata[MIS_POS_TACH1 +: 2]; // see R17
			tach2_prescale_o <= reg_req_i.wdata[MIS_POS_TACH2 +: 2]; // see R18
		end
	end

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			reg_rdata_o <= MIS_RST_ZERO;
		else if (reg_req_i.rd) begin
			unique case (reg_req_i.addr)
				MIS_OFS_STATUS_A: reg_rdata_o <= status_a;
				MIS_OFS_STATUS_B: reg_rdata_o <= status_b;
				MIS_OFS_MASK_A:   reg_rdata_o <= mask_a;
				MIS_OFS_MASK_B:   reg_rdata_o <= mask_b;
				MIS_OFS_INTR_CLR: reg_rdata_o <= {pulse_active, 7'h00}; // see R14 see R15
				MIS_OFS_VID_TACH: reg_rdata_o <= {tach2_prescale_o, tach1_prescale_o, vid_s}; // see R16
				default:          reg_rdata_o <= MIS_RST_ZERO;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_read_clears: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R07
		rd_a && !irq_clear_i && limit_events_i.events_a == 8'h00 |=> status_a == 8'h00)
		else $error("status A not cleared by read");
	chk_set_wins: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R08
		rd_a && set_a[0] |=> status_a[0])
		else $error("event lost on read");
	chk_mask_blocks: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R09
		(status_a & ~mask_a) == 8'h00 && (status_b & ~mask_b) == 8'h00 |=> !irq_o)
		else $error("masked status raised irq");
	chk_irq_raise: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R21
		pending && irq_enable_i && !irq_clear_i |=> irq_o)
		else $error("irq not raised");
	chk_irq_enable: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R19
		!irq_enable_i |=> !irq_o)
		else $error("irq while disabled");
	chk_irq_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R20
		irq_clear_i |=> !irq_o && ($stable(status_a) || $past(rd_a)))
		else $error("irq clear misbehaved");
	chk_mask_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R10
		reg_req_i.wr && reg_req_i.addr == MIS_OFS_MASK_B |=> mask_b == $past(reg_req_i.wdata))
		else $error("mask B write lost");
	chk_pulse_start: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R13
		intr_req && !pulse_active |=> !intrusion_oe_n_o [*8])
		else $error("intrusion pulse too short");
	chk_pulse_end: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R14
		pulse_active && pulse_cnt == 32'h0 |=> !pulse_active)
		else $error("request bit not self cleared");
	chk_prescale: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R17
		reg_req_i.wr && reg_req_i.addr == MIS_OFS_VID_TACH |=> tach1_prescale_o == $past(reg_req_i.wdata[5:4]))
		else $error("tach prescale not written");

	// ----------------------------------------------------------------
	// Checks on event capture
	// ----------------------------------------------------------------
	chk_status_a_set: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R01
		!irq_clear_i |=> (status_a & $past(limit_events_i.events_a)) == $past(limit_events_i.events_a))
		else $error("status A event lost");
	chk_temp_bits: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R02
		!irq_clear_i |=> (status_a[5:4] & $past(limit_events_i.events_a[5:4])) == $past(limit_events_i.events_a[5:4]))
		else $error("temperature event lost");
	chk_status_b_set: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R03
		!irq_clear_i |=> (status_b[1:0] & $past(limit_events_i.events_b[1:0])) == $past(limit_events_i.events_b[1:0]))
		else $error("status B supply event lost");
	chk_reserved_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R03
		status_b[3:2] == 2'h0)
		else $error("reserved status bits set");
	chk_intrusion_set: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R04
		intrusion_s && !intrusion_prev && !pulse_active && !irq_clear_i |=> status_b[MIS_BIT_INTRUSION])
		else $error("intrusion edge lost");
	chk_overtemp_set: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R05
		!overtemp_s && !own_drive && !irq_clear_i |=> status_b[MIS_BIT_OVERTEMP])
		else $error("external overtemp lost");
	chk_own_drive: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R05
		own_drive && !status_b[MIS_BIT_OVERTEMP] |=> !status_b[MIS_BIT_OVERTEMP])
		else $error("own overtemp drive flagged");
	chk_diode_set: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R06
		!irq_clear_i |=> (status_b[7:6] & $past(limit_events_i.events_b[7:6])) == $past(limit_events_i.events_b[7:6]))
		else $error("diode fault lost");
	chk_read_clears_b: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R07
		rd_b && set_b == 8'h00 |=> status_b == 8'h00)
		else $error("status B not cleared by read");
	chk_refire: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R08
		rd_a && (status_b & ~mask_b) != 8'h00 |=> pending)
		else $error("remaining status lost on read");

	// ----------------------------------------------------------------
	// Checks on masks, interrupt and fields
	// ----------------------------------------------------------------
	chk_mask_a_write: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R10
		reg_req_i.wr && reg_req_i.addr == MIS_OFS_MASK_A |=> mask_a == $past(reg_req_i.wdata))
		else $error("mask A write lost");
	chk_mask_b_resv: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R11
		reg_req_i.wr && reg_req_i.addr == MIS_OFS_MASK_B |=> mask_b[3:2] == $past(reg_req_i.wdata[3:2]))
		else $error("mask B reserved bits not writable");
	chk_irq_drop: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R21
		!pending |=> !irq_o)
		else $error("irq held without pending status");
	chk_pause_follow: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R20
		monitor_pause_o == irq_clear_i)
		else $error("pause does not follow clear");
	chk_vid_read: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R16
		reg_req_i.rd && reg_req_i.addr == MIS_OFS_VID_TACH |=> reg_rdata_o[3:0] == $past(vid_s))
		else $error("voltage id read wrong");
	chk_prescale_two: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R18
		reg_req_i.wr && reg_req_i.addr == MIS_OFS_VID_TACH |=> tach2_prescale_o == $past(reg_req_i.wdata[7:6]))
		else $error("tach two prescale not written");
	chk_prescale_hold: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R17
		!(reg_req_i.wr && reg_req_i.addr == MIS_OFS_VID_TACH) |=> $stable({tach2_prescale_o, tach1_prescale_o}))
		else $error("tach prescale changed without write");

	// ----------------------------------------------------------------
	// Checks on the intrusion pulse
	// ----------------------------------------------------------------
	chk_pulse_length: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R13
		$fell(pulse_active) |-> $past(low_cycles) == 32'(MIS_PULSE_CYC - 1))
		else $error("intrusion pulse length wrong");
	chk_pulse_bound: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R13
		pulse_active |-> low_cycles < 32'(MIS_PULSE_CYC))
		else $error("intrusion pulse too long");
	chk_pulse_req_bit: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R14
		reg_req_i.rd && reg_req_i.addr == MIS_OFS_INTR_CLR |=> reg_rdata_o[7] == $past(pulse_active))
		else $error("request bit does not show pulse");
	chk_clear_read: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // see R15
		reg_req_i.rd && reg_req_i.addr == MIS_OFS_INTR_CLR |=> reg_rdata_o[6:0] == 7'h00)
		else $error("intrusion clear low bits not zero");

endmodule // mis_monitor_irq

// ### inc/mis_pkg.sv
/*
 Package for the monitor interrupt status and mask block: register offsets,
 field positions, reset values, timing counts and the carrier structs.
 Assumes a 10 MHz core clock.
*/
package mis_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] MIS_OFS_STATUS_A  = 8'h41;
	localparam logic [7:0] MIS_OFS_STATUS_B  = 8'h42;
	localparam logic [7:0] MIS_OFS_MASK_A    = 8'h43;
	localparam logic [7:0] MIS_OFS_MASK_B    = 8'h44;
	localparam logic [7:0] MIS_OFS_INTR_CLR  = 8'h46;
	localparam logic [7:0] MIS_OFS_VID_TACH  = 8'h47;

	// ----------------------------------------------------------------
	// Reset values and fields
	// ----------------------------------------------------------------
	localparam logic [7:0] MIS_RST_STATUS    = 8'h00;
	localparam logic [7:0] MIS_RST_MASK      = 8'h00;
	localparam logic [7:0] MIS_RST_ZERO      = 8'h00;
	localparam logic [1:0] MIS_RST_PRESCALE  = 2'h0;
	localparam logic [5:0] MIS_RST_SYNC      = 6'h02;
	localparam int         MIS_BIT_INTR_REQ  = 7;
	localparam int         MIS_POS_VID       = 0;
	localparam int         MIS_POS_TACH1     = 4;
	localparam int         MIS_POS_TACH2     = 6;
	localparam int         MIS_BIT_INTRUSION = 4;
	localparam int         MIS_BIT_OVERTEMP  = 5;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int         MIS_CLK_HZ        = 10_000_000;
	localparam int         MIS_PULSE_MS      = 20;
	localparam int         MIS_PULSE_CYC     = (MIS_CLK_HZ / 1000) * MIS_PULSE_MS;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mis_reg_req_s;

	typedef struct packed {
		logic [7:0] events_a;
		logic [7:0] events_b;
	} mis_events_s;

	typedef enum logic [1:0] {
		MIS_PULSE_IDLE = 2'b00,
		MIS_PULSE_LOW  = 2'b01
	} mis_pulse_e;

endpackage

// ### testbench/mis_host_model.sv
/*
 Register host model: issues one-cycle read or write strobes.
 Assumes the block takes a strobe at a rising edge of core_clk_i.
*/
`timescale 1ns/100ps
module mis_host_model
	import mis_pkg::*;
(
	input  wire logic             core_clk_i,
	output mis_pkg::mis_reg_req_s reg_req_o,
	input  wire logic [7:0]       rdata_i
);
	initial reg_req_o = '0;
	// Strobe launched and dropped at falling edges, answer taken as it drops
	task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
		@(negedge core_clk_i);
		reg_req_o <= {w, ~w, a, d};
		@(negedge core_clk_i);
		reg_req_o <= '0;
		q = rdata_i;
	endtask
endmodule // mis_host_model

// ### testbench/tb.sv
/*
 Self-checking bench for the monitor irq block with a behavioural model.
 Assumes the host model file and mis_pkg are compiled first.
*/
`timescale 1ns/100ps
module tb;
	import mis_pkg::*;
	logic         core_clk_i, rst_n_i, en, clr, intr, ot_line, ot_drv, irq, pause, i_out, i_oe_n;
	mis_reg_req_s req;
	mis_events_s  ev;
	logic [3:0]   processor_voltage_id;
	logic [7:0]   rdata, q, ea, eb, ma, mb;
	logic [1:0]   t1, t2;
	int           miscompares = 0, cmp_count = 0, cyc = 0;

	mis_host_model host (.core_clk_i(core_clk_i), .reg_req_o(req), .rdata_i(rdata));
	mis_monitor_irq dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .reg_req_i(req), .reg_rdata_o(rdata),
		.limit_events_i(ev), .irq_enable_i(en), .irq_clear_i(clr), .monitor_pause_o(pause), .irq_o(irq),
		.intrusion_in_i(intr & i_oe_n), .intrusion_out_o(i_out), .intrusion_oe_n_o(i_oe_n),
		.overtemp_line_in_i(ot_line), .overtemp_drive_i(ot_drv), .processor_voltage_id_i(processor_voltage_id),
		.tach1_prescale_o(t1), .tach2_prescale_o(t2));

	// ----------------------------------------------------------------
	// Clock, timeout and shared tasks
	// ----------------------------------------------------------------
	initial begin
		core_clk_i = 0;
		forever #50 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 10000) begin
			miscompares++;
			complete_run();
		end
	end
	task automatic check(input string n, input logic [7:0] s, input logic [7:0] e);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		host.access(1'b0, a, 8'h00, q);
		check($sformatf("reg %h", a), q, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.access(1'b1, a, d, q);
	endtask
	task automatic rd_st(input logic [7:0] a);
		if (a == MIS_OFS_STATUS_A) begin
			rd(a, ea);
			ea = 8'h00;
		end else begin
			rd(a, eb);
			eb = 8'h00;
		end
	endtask
	task automatic irqc();
		@(negedge core_clk_i);
		check("irq", {7'h0, irq}, {7'h0, en & ~clr & (|((ea & ~ma) | (eb & ~mb)))});
	endtask
	task automatic fire(input logic [7:0] a, input logic [7:0] b);
		@(negedge core_clk_i);
		ev = {a, b};
		@(negedge core_clk_i);
		ev = '0;
		if (!clr) begin
			ea |= a;
			eb |= b & 8'hC3;
		end
		repeat (2) @(negedge core_clk_i);
		irqc();
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial begin
		q = $urandom(32'h68cb2232);
		{rst_n_i, en, clr, intr, ot_drv} = '0;
		ot_line = 1;
		ev = '0;
		processor_voltage_id = 4'h5;
		{ea, eb, ma, mb} = '0;
		repeat (12) @(negedge core_clk_i);
		rst_n_i = 1;
		wr(MIS_OFS_STATUS_A, 8'hFF);
		for (int i = 0; i < 6; i++) rd(8'h41 + 8'(i), 8'h00);
		rd(MIS_OFS_VID_TACH, 8'h05);
		$display("test reset done");
		en = 1;
		repeat (8) begin
			ma = $urandom & $urandom;
			mb = $urandom & $urandom;
			wr(MIS_OFS_MASK_A, ma);
			wr(MIS_OFS_MASK_B, mb);
			rd(MIS_OFS_MASK_A, ma);
			rd(MIS_OFS_MASK_B, mb);
			fire($urandom, $urandom);
			rd_st(MIS_OFS_STATUS_A);
			irqc();
			rd_st(MIS_OFS_STATUS_B);
			irqc();
		end
		$display("test events done");
		{ma, mb} = '0;
		wr(MIS_OFS_MASK_A, ma);
		wr(MIS_OFS_MASK_B, mb);
		fire(8'h81, 8'h00);
		en = 0;
		repeat (2) irqc();
		en = 1;
		clr = 1;
		repeat (2) irqc();
		check("pause", {7'h0, pause}, 8'h01);
		fire(8'h7E, 8'hC3);
		clr = 0;
		ev = {8'h01, 8'h00};
		rd_st(MIS_OFS_STATUS_A);
		ev = '0;
		ea = 8'h01;
		rd_st(MIS_OFS_STATUS_A);
		intr = 1;
		ot_drv = 1;
		ot_line = 0;
		repeat (4) @(negedge core_clk_i);
		eb |= 8'h10;
		ot_line = 1;
		repeat (4) @(negedge core_clk_i);
		ot_drv = 0;
		rd_st(MIS_OFS_STATUS_B);
		ot_line = 0;
		repeat (4) @(negedge core_clk_i);
		eb |= 8'h20;
		ot_line = 1;
		irqc();
		rd_st(MIS_OFS_STATUS_B);
		$display("test pins done");
		for (int i = 0; i < 4; i++) begin
			processor_voltage_id = $urandom;
			wr(MIS_OFS_VID_TACH, {i[1:0], ~i[1:0], 4'hF});
			repeat (3) @(negedge core_clk_i);
			rd(MIS_OFS_VID_TACH, {i[1:0], ~i[1:0], processor_voltage_id});
			check("tach", {4'h0, t2, t1}, {4'h0, i[1:0], ~i[1:0]});
		end
		$display("test prescale done");
		wr(MIS_OFS_INTR_CLR, 8'hFF);
		check("oe_n", {6'h0, i_oe_n, i_out}, 8'h00);
		rd(MIS_OFS_INTR_CLR, 8'h80);
		repeat (1000) @(negedge core_clk_i);
		check("oe_n held", {7'h0, i_oe_n}, 8'h00);
		$display("test pulse done");
		complete_run();
	end
endmodule // tb
